// [logic/bpoc_pkg.sv]
// Shared constants and types for the brushless output-stage controller.
package bpoc_pkg;

  // ****************************************************************
  // Clock and carrier timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 40;
  // Carrier period is the timing constant times the timing capacitance.
  localparam int unsigned CARRIER_OHM = 45000;
  localparam int unsigned CARRIER_CAP_PF = 1000;
  localparam int unsigned CARRIER_CYC = CLK_MHZ * CARRIER_OHM * CARRIER_CAP_PF / 1000000;
  localparam int unsigned RAMP_W = 11;
  localparam logic [RAMP_W-1:0] RAMP_RESET = 11'h000;
  localparam logic [RAMP_W-1:0] RAMP_LAST = RAMP_W'(CARRIER_CYC - 1);

  // ****************************************************************
  // Duty compare levels (digitised compare node, 20 mV per code)
  // ****************************************************************
  localparam int unsigned LEVEL_W = 8;
  localparam int unsigned LEVEL_MV_LSB = 20;
  localparam int unsigned DUTY_OFF_MV = 3000;
  localparam int unsigned DUTY_FULL_MV = 1200;
  localparam logic [LEVEL_W-1:0] DUTY_OFF_CODE = LEVEL_W'(DUTY_OFF_MV / LEVEL_MV_LSB);
  localparam logic [LEVEL_W-1:0] DUTY_FULL_CODE = LEVEL_W'(DUTY_FULL_MV / LEVEL_MV_LSB);

  // ****************************************************************
  // Current-limit spike filter (least time, rounded up)
  // ****************************************************************
  localparam int unsigned CL_FILTER_NS = 500;
  localparam int unsigned CL_FILTER_CYC = (CL_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FILT_W = 5;

  // ****************************************************************
  // Lock protection timing
  // ****************************************************************
  localparam int unsigned LOCK_TIME_MS = 1540;
  localparam int unsigned LOCK_CYC = LOCK_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned UNLOCK_ZERO_MS = 10;
  localparam int unsigned UNLOCK_CYC = UNLOCK_ZERO_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;

  // ****************************************************************
  // Hall codes and drive encodings
  // ****************************************************************
  localparam logic [2:0] HALL_ILLEGAL = 3'h7;
  localparam logic [2:0] PHASE_NONE = 3'h0;
  localparam logic [2:0] PHASE_A = 3'h1;
  localparam logic [2:0] PHASE_B = 3'h2;
  localparam logic [2:0] PHASE_C = 3'h4;

  // Main sequence states, Gray coded along stop, run, locked.
  typedef enum logic [1:0] {
    BPOC_STOP = 2'h0,
    BPOC_RUN = 2'h1,
    BPOC_LOCKED = 2'h3
  } bpoc_state_t;

endpackage : bpoc_pkg

// [logic/bpoc_deglitch.sv]
// Deglitch filter that passes a high level only after it has held for a set time; a low level passes at once.
`timescale 1ns/1ps
`default_nettype none

module bpoc_deglitch #(
  parameter int unsigned HOLD_CYC = bpoc_pkg::CL_FILTER_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic raw_in,
  output logic filt_out
);
  import bpoc_pkg::*;

  typedef struct packed {
    logic [FILT_W-1:0] cnt;
    logic filt;
  } bpoc_dg_state_t;

  localparam logic [FILT_W-1:0] HOLD_LAST = FILT_W'(HOLD_CYC - 1);
  localparam logic [FILT_W-1:0] DG_ZERO = 5'h00;

  bpoc_dg_state_t st_r;
  bpoc_dg_state_t st_nxt;

  // Count consecutive high samples; any low sample restarts the count, so a
  // recovery spike shorter than the hold time never reaches the output.
  always_comb begin
    st_nxt = st_r;
    if (!raw_in) begin
      st_nxt.cnt = DG_ZERO;
      st_nxt.filt = 1'b0;
    end else if (st_r.cnt == HOLD_LAST) begin
      st_nxt.filt = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 5'h01;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign filt_out = st_r.filt;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dg_cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  spike_blocked_a: assert property (!raw_in |=> !filt_out)
    else $error("Filter output high after a low sample.");
  hold_passes_a: assert property (raw_in [*8] ##1 (raw_in && st_r.cnt == HOLD_LAST) |=> filt_out)
    else $error("Filter output low after full hold time.");

endmodule : bpoc_deglitch

`default_nettype wire

// [logic/bpoc_top.sv]
// Output-stage controller: commutation, PWM chopping and output gating.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Only high-side drives are chopped; low sides follow commutation alone.
// - Stop or supply below operating level puts all six outputs high-impedance.
// - Filtered current-limit trip cuts high-side on-time for the carrier period.
// - Current-limit trip is filtered so short recovery spikes are ignored.
// - Stop mode asserts power save; 5 V regulator enable stays on always.
// - Carrier period is timing constant times timing capacitance, in clock cycles.
// - Compare level above 3.0 V gives 0% duty, below 1.2 V gives 100%.
// - Pulse mode enables high-side drive while pulse input is low, cuts it while high; low sides stay driven.
// - All three Hall inputs high switches off all six outputs.
// - Hall input changes are the event source for lock protection.
// - Supply below trip turns high sides off until it rises past release.
// - No Hall change for the lock period while driving turns high sides off.
module bpoc_top #(
  parameter int unsigned LOCK_CYCLES = bpoc_pkg::LOCK_CYC,
  parameter int unsigned UNLOCK_CYCLES = bpoc_pkg::UNLOCK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic stop_in,
  input wire logic dir_reverse_in,
  input wire logic pulse_mode_in,
  input wire logic pulse_duty_n_in,
  input wire logic [bpoc_pkg::LEVEL_W-1:0] duty_compare_level_in,
  input wire logic current_sense_trip_in,
  input wire logic supply_below_operating_in,
  input wire logic supply_sense_below_trip_in,
  input wire logic supply_sense_above_release_in,
  input wire logic [2:0] hall_in,
  output logic phase_a_high_drive_out,
  output logic phase_b_high_drive_out,
  output logic phase_c_high_drive_out,
  output logic phase_a_low_drive_out,
  output logic phase_b_low_drive_out,
  output logic phase_c_low_drive_out,
  output logic drive_oe_out,
  output logic power_save_out,
  output logic regulated_5v_enable_out,
  output logic hall_event_out,
  output logic current_limit_out,
  output logic undervoltage_off_out,
  output logic lock_protect_out
);
  import bpoc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bpoc_state_t mode;
    logic [RAMP_W-1:0] ramp;
    logic lim_cut;
    logic uv_off;
    logic [CNT_W-1:0] lock_cnt;
    logic [CNT_W-1:0] zero_cnt;
    logic [2:0] hall_prev;
    logic hall_evt;
    logic [2:0] hi;
    logic [2:0] lo;
    logic oe;
    logic psave;
  } bpoc_top_state_t;

  bpoc_top_state_t st_r;
  bpoc_top_state_t st_nxt;
  logic lim_filt;
  logic [2:0] comm_hi;
  logic [2:0] comm_lo;
  logic duty_on;
  logic chop_on;
  logic gate_off;
  logic [31:0] duty_lhs;
  logic [31:0] duty_rhs;

  // The spike filter is a separate module so its hold time can be tuned alone.
  bpoc_deglitch #(
    .HOLD_CYC(CL_FILTER_CYC)
  ) u_limit_filter (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .raw_in(current_sense_trip_in),
    .filt_out(lim_filt)
  );

  // ****************************************************************
  // Commutation decode
  // ****************************************************************
  // Forward order pairs one high and one low phase; reverse swaps the pair,
  // which reverses the torque without a second table.
  always_comb begin
    comm_hi = PHASE_NONE;
    comm_lo = PHASE_NONE;
    unique case (hall_in)
      3'h1: begin
        comm_hi = PHASE_A;
        comm_lo = PHASE_B;
      end
      3'h3: begin
        comm_hi = PHASE_A;
        comm_lo = PHASE_C;
      end
      3'h2: begin
        comm_hi = PHASE_B;
        comm_lo = PHASE_C;
      end
      3'h6: begin
        comm_hi = PHASE_B;
        comm_lo = PHASE_A;
      end
      3'h4: begin
        comm_hi = PHASE_C;
        comm_lo = PHASE_A;
      end
      3'h5: begin
        comm_hi = PHASE_C;
        comm_lo = PHASE_B;
      end
      3'h0, 3'h7: begin
        comm_hi = PHASE_NONE;
        comm_lo = PHASE_NONE;
      end
    endcase
    if (dir_reverse_in) begin
      {comm_hi, comm_lo} = {comm_lo, comm_hi};
    end
  end

  // ****************************************************************
  // Duty compare against the carrier ramp
  // ****************************************************************
  // The ramp is mapped onto the band between the two levels by cross
  // multiplication, which avoids a divider in the compare path.
  assign duty_lhs = 32'(DUTY_OFF_CODE - duty_compare_level_in) * 32'(CARRIER_CYC);
  assign duty_rhs = 32'(st_r.ramp) * 32'(DUTY_OFF_CODE - DUTY_FULL_CODE);

  always_comb begin
    if (duty_compare_level_in >= DUTY_OFF_CODE) begin
      duty_on = 1'b0;
    end else if (duty_compare_level_in <= DUTY_FULL_CODE) begin
      duty_on = 1'b1;
    end else begin
      duty_on = duty_lhs > duty_rhs;
    end
  end

  // Pulse mode ignores the compare level; the host keeps it at full duty.
  assign chop_on = pulse_mode_in ? !pulse_duty_n_in : duty_on;
  assign gate_off = stop_in || supply_below_operating_in;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;

    // Free-running carrier ramp.
    if (st_r.ramp == RAMP_LAST) begin
      st_nxt.ramp = RAMP_RESET;
    end else begin
      st_nxt.ramp = st_r.ramp + 11'h001;
    end

    // Cycle-by-cycle limit: cleared at the period start, but a trip in that
    // same cycle wins so no over-current event is lost.
    if (lim_filt) begin
      st_nxt.lim_cut = 1'b1;
    end else if (st_r.ramp == RAMP_LAST) begin
      st_nxt.lim_cut = 1'b0;
    end

    // Undervoltage with hysteresis: trip and release are separate levels.
    if (supply_sense_below_trip_in) begin
      st_nxt.uv_off = 1'b1;
    end else if (supply_sense_above_release_in) begin
      st_nxt.uv_off = 1'b0;
    end

    // Hall change detect feeds the lock timer.
    st_nxt.hall_prev = hall_in;
    st_nxt.hall_evt = hall_in != st_r.hall_prev;

    // Mode sequence and lock timing.
    unique case (st_r.mode)
      BPOC_STOP: begin
        st_nxt.lock_cnt = CNT_RESET;
        st_nxt.zero_cnt = CNT_RESET;
        if (!stop_in) begin
          st_nxt.mode = BPOC_RUN;
        end
      end
      BPOC_RUN: begin
        if (stop_in) begin
          st_nxt.mode = BPOC_STOP;
        end else if (st_r.hall_evt || !chop_on) begin
          st_nxt.lock_cnt = CNT_RESET;
        end else if (st_r.lock_cnt == CNT_W'(LOCK_CYCLES - 1)) begin
          st_nxt.mode = BPOC_LOCKED;
          st_nxt.zero_cnt = CNT_RESET;
        end else begin
          st_nxt.lock_cnt = st_r.lock_cnt + 32'h00000001;
        end
      end
      BPOC_LOCKED: begin
        // Release by stop, or by holding zero duty long enough.
        st_nxt.lock_cnt = CNT_RESET;
        if (stop_in) begin
          st_nxt.mode = BPOC_STOP;
        end else if (chop_on) begin
          st_nxt.zero_cnt = CNT_RESET;
        end else if (st_r.zero_cnt == CNT_W'(UNLOCK_CYCLES - 1)) begin
          st_nxt.mode = BPOC_RUN;
          st_nxt.zero_cnt = CNT_RESET;
        end else begin
          st_nxt.zero_cnt = st_r.zero_cnt + 32'h00000001;
        end
      end
      default: begin
        st_nxt.mode = BPOC_STOP;
      end
    endcase

    // Output stage. Low sides take commutation only, never the chop.
    st_nxt.psave = stop_in;
    st_nxt.oe = !gate_off;
    st_nxt.lo = gate_off ? PHASE_NONE : comm_lo;
    if (gate_off || hall_in == HALL_ILLEGAL) begin
      st_nxt.hi = PHASE_NONE;
      st_nxt.lo = PHASE_NONE;
    end else if (!chop_on || lim_filt || st_r.lim_cut || st_r.uv_off
                 || supply_sense_below_trip_in || st_r.mode != BPOC_RUN) begin
      st_nxt.hi = PHASE_NONE;
    end else begin
      st_nxt.hi = comm_hi;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset comes up in stop with outputs released, as after power-up.
  // The Hall history loads the live code, so no false change event follows reset.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= '{mode: BPOC_STOP, ramp: RAMP_RESET, lim_cut: 1'b0, uv_off: 1'b1,
                lock_cnt: CNT_RESET, zero_cnt: CNT_RESET, hall_prev: hall_in,
                hall_evt: 1'b0, hi: PHASE_NONE, lo: PHASE_NONE, oe: 1'b0,
                psave: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign phase_a_high_drive_out = st_r.hi[0];
  assign phase_b_high_drive_out = st_r.hi[1];
  assign phase_c_high_drive_out = st_r.hi[2];
  assign phase_a_low_drive_out = st_r.lo[0];
  assign phase_b_low_drive_out = st_r.lo[1];
  assign phase_c_low_drive_out = st_r.lo[2];
  assign drive_oe_out = st_r.oe;
  assign power_save_out = st_r.psave;
  // The regulator stays on in power save so Hall bias remains available.
  assign regulated_5v_enable_out = 1'b1;
  assign hall_event_out = st_r.hall_evt;
  assign current_limit_out = st_r.lim_cut;
  assign undervoltage_off_out = st_r.uv_off;
  assign lock_protect_out = st_r.mode == BPOC_LOCKED;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking top_cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  outputs_hiz_a: assert property (gate_off |=> !drive_oe_out && st_r.hi == PHASE_NONE)
    else $error("Outputs not released in stop or low supply.");
  low_no_chop_a: assert property (!gate_off && hall_in != HALL_ILLEGAL
                                  |=> st_r.lo == $past(comm_lo))
    else $error("Low-side drive differs from commutation.");
  limit_cuts_a: assert property (lim_filt |=> st_r.hi == PHASE_NONE && current_limit_out)
    else $error("High side on during current limit.");
  save_mode_a: assert property (stop_in |=> power_save_out && regulated_5v_enable_out)
    else $error("Power save or regulator wrong in stop.");
  carrier_wrap_a: assert property (st_r.ramp == RAMP_LAST |=> st_r.ramp == RAMP_RESET)
    else $error("Carrier ramp did not wrap at period end.");
  duty_zero_a: assert property (!pulse_mode_in && duty_compare_level_in >= DUTY_OFF_CODE
                                |=> st_r.hi == PHASE_NONE)
    else $error("High side on with compare level above off level.");
  pulse_off_a: assert property (pulse_mode_in && pulse_duty_n_in |=> st_r.hi == PHASE_NONE)
    else $error("High side on with pulse input high.");
  hall_illegal_a: assert property (hall_in == HALL_ILLEGAL
                                   |=> st_r.hi == PHASE_NONE && st_r.lo == PHASE_NONE)
    else $error("Outputs on with illegal Hall code.");
  hall_event_a: assert property ($changed(hall_in) |=> hall_event_out ##1 st_r.lock_cnt == CNT_RESET
                                 || st_r.mode != BPOC_RUN || stop_in)
    else $error("Hall change did not restart lock timer.");
  uv_hold_a: assert property (undervoltage_off_out && !supply_sense_above_release_in
                              |=> undervoltage_off_out && st_r.hi == PHASE_NONE)
    else $error("High side restored before release level.");
  lock_off_a: assert property (lock_protect_out && !stop_in |=> st_r.hi == PHASE_NONE)
    else $error("High side on while lock protection active.");
  one_pair_a: assert property (drive_oe_out |-> $onehot0(st_r.hi) && $onehot0(st_r.lo)
                               && (st_r.hi & st_r.lo) == PHASE_NONE)
    else $error("Drive pair not a single high and low phase.");

  limit_seen_c: cover property (lim_filt ##1 current_limit_out);
  lock_seen_c: cover property (st_r.mode == BPOC_RUN ##1 lock_protect_out);
  chop_seen_c: cover property (st_r.hi != PHASE_NONE ##1 st_r.hi == PHASE_NONE && !gate_off);
  uv_seen_c: cover property ($fell(undervoltage_off_out));

endmodule : bpoc_top

`default_nettype wire

// [tb/bpoc_plant.sv]
// Model of the Hall sensors, current-sense comparator and host speed source.
`timescale 1ns/1ps
`default_nettype none

module bpoc_plant (
  input wire logic clk_in,
  input wire logic [2:0] pos_in,
  input wire logic hall_bad_in,
  input wire logic pulse_mode_in,
  input wire logic pulse_off_in,
  input wire logic [7:0] level_in,
  input wire logic spike_go_in,
  input wire logic [7:0] spike_len_in,
  output logic [2:0] hall_out,
  output logic pulse_duty_n_out,
  output logic [7:0] level_out,
  output logic trip_out
);
  // *****
  // Sensors and host
  // *****
  localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  logic [7:0] left_r = 8'h00;

  // Forward rotation walks this code order; a shorted sensor reads all three high.
  assign hall_out = hall_bad_in ? 3'h7 : SEQ[pos_in];
  // The host keeps the pulse input low unless it controls by pulses.
  assign pulse_duty_n_out = pulse_mode_in ? pulse_off_in : 1'b0;
  // In pulse mode the host grounds the compare node for full duty.
  assign level_out = pulse_mode_in ? 8'h00 : level_in;
  // Recovery spikes last a set count; changed after the edge to avoid races.
  always @(posedge clk_in) begin
    left_r <= #2 spike_go_in ? spike_len_in : (left_r != 8'h00 ? left_r - 8'h01 : 8'h00);
  end
  assign trip_out = (left_r != 8'h00);
endmodule : bpoc_plant

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the brushless output-stage controller.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bpoc_pkg::*;
  // *****
  // Signals and instances
  // *****
  localparam int unsigned LOCK_N = 4000;
  localparam int PER = int'(RAMP_LAST) + 1;
  logic clk_in = 0, rst_n = 0, stop = 0, dir = 0, pmode = 0, poff = 1;
  logic uv_op = 0, uv_trip = 0, uv_rel = 1, bad_h = 0, go = 0;
  logic [2:0] pos = 3'h0;
  logic [7:0] lvl = 8'h00, slen = 8'h00;
  wire [2:0] hall;
  wire [7:0] dlvl;
  wire [5:0] drv;
  wire pdn, trip, oe, psave, r5v, hev, lim, uvo, lck;
  int err_total = 0;
  int num_checks = 0;

  bpoc_top #(.LOCK_CYCLES(LOCK_N), .UNLOCK_CYCLES(50)) bpoc_top_i (
    .clk_in(clk_in), .rst_n_in(rst_n), .stop_in(stop), .dir_reverse_in(dir),
    .pulse_mode_in(pmode), .pulse_duty_n_in(pdn), .duty_compare_level_in(dlvl),
    .current_sense_trip_in(trip), .supply_below_operating_in(uv_op),
    .supply_sense_below_trip_in(uv_trip), .supply_sense_above_release_in(uv_rel),
    .hall_in(hall), .phase_a_high_drive_out(drv[3]), .phase_b_high_drive_out(drv[4]),
    .phase_c_high_drive_out(drv[5]), .phase_a_low_drive_out(drv[0]),
    .phase_b_low_drive_out(drv[1]), .phase_c_low_drive_out(drv[2]), .drive_oe_out(oe),
    .power_save_out(psave), .regulated_5v_enable_out(r5v), .hall_event_out(hev),
    .current_limit_out(lim), .undervoltage_off_out(uvo), .lock_protect_out(lck));

  bpoc_plant bpoc_plant_i (.clk_in(clk_in), .pos_in(pos), .hall_bad_in(bad_h),
    .pulse_mode_in(pmode), .pulse_off_in(poff), .level_in(lvl), .spike_go_in(go),
    .spike_len_in(slen), .hall_out(hall), .pulse_duty_n_out(pdn), .level_out(dlvl),
    .trip_out(trip));

  // *****
  // Helpers
  // *****
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : cyc
  task automatic bad(input string m);
    err_total++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : bad
  task automatic chk_bit(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) bad(m);
  endtask : chk_bit
  task automatic chk_drv(input logic [5:0] e, input string m);
    num_checks++;
    if (drv !== e) bad(m);
  endtask : chk_drv
  task automatic chk_cnt(input int g, input int e, input string m);
    num_checks++;
    if (g != e) bad(m);
  endtask : chk_cnt
  // Expected {high c,b,a, low c,b,a}; reverse swaps the two halves.
  function automatic logic [5:0] pair(input logic [2:0] h, input logic r);
    logic [5:0] p;
    case (h)
      3'h1: p = 6'h0A;
      3'h3: p = 6'h0C;
      3'h2: p = 6'h14;
      3'h6: p = 6'h11;
      3'h4: p = 6'h21;
      3'h5: p = 6'h22;
      default: p = 6'h00;
    endcase
    return r ? {p[2:0], p[5:3]} : p;
  endfunction : pair
  // Moving the rotor also restarts the stall timer inside the block.
  task automatic step();
    pos = (pos == 3'h5) ? 3'h0 : pos + 3'h1;
  endtask : step
  function automatic logic [5:0] lows();
    return pair(hall, dir) & 6'h07;
  endfunction : lows

  // *****
  // Scenarios
  // *****
  task automatic t_comm();
    int n;
    for (int r = 0; r < 2; r++) begin
      dir = r[0];
      for (int k = 0; k < 6; k++) begin
        step();
        n = 0;
        repeat (4) begin
          cyc(1);
          if (hev === 1'b1) n++;
        end
        chk_cnt(n, 1, "hall event count");
        chk_drv(pair(hall, dir), "commutation pair");
      end
    end
    dir = 0;
    bad_h = 1;
    cyc(3);
    chk_drv(6'h00, "all-high hall");
    bad_h = 0;
    $display("test commutation done");
  endtask : t_comm

  task automatic t_chop();
    int lv [5] = '{int'(DUTY_FULL_CODE), int'(DUTY_FULL_CODE) + 1, 105,
                   int'(DUTY_OFF_CODE) - 1, int'(DUTY_OFF_CODE)};
    int span, e, nh, nl;
    span = int'(DUTY_OFF_CODE) - int'(DUTY_FULL_CODE);
    foreach (lv[i]) begin
      step();
      lvl = lv[i][7:0];
      e = (lv[i] <= int'(DUTY_FULL_CODE)) ? PER : (lv[i] >= int'(DUTY_OFF_CODE)) ? 0 :
          ((int'(DUTY_OFF_CODE) - lv[i]) * PER + span - 1) / span;
      cyc(3);
      nh = 0;
      nl = 0;
      repeat (PER) begin
        cyc(1);
        if (drv === pair(hall, dir)) nh++;
        if (drv === lows() || drv === pair(hall, dir)) nl++;
      end
      chk_cnt(nh, e, "high on-cycles per carrier period");
      chk_cnt(nl, PER, "low side chopped");
    end
    lvl = 8'h00;
    $display("test chop done");
  endtask : t_chop

  task automatic t_pulse();
    pmode = 1;
    poff = 0;
    cyc(3);
    chk_drv(pair(hall, dir), "pulse low drives");
    poff = 1;
    cyc(3);
    chk_drv(lows(), "pulse high stops high sides");
    pmode = 0;
    cyc(3);
    $display("test pulse done");
  endtask : t_pulse

  task automatic t_limit();
    int n;
    step();
    slen = 8'd19;
    go = 1;
    cyc(1);
    go = 0;
    n = 0;
    repeat (30) begin
      cyc(1);
      if (lim !== 1'b0 || drv !== pair(hall, dir)) n++;
    end
    chk_cnt(n, 0, "short spike filtered");
    slen = 8'd25;
    go = 1;
    cyc(1);
    go = 0;
    cyc(25);
    chk_bit(lim, 1'b1, "limit flag");
    chk_drv(lows(), "limit cuts high side");
    cyc(PER + 30);
    chk_drv(pair(hall, dir), "limit released");
    $display("test limit done");
  endtask : t_limit

  task automatic t_uv();
    uv_trip = 1;
    uv_rel = 0;
    cyc(3);
    chk_drv(lows(), "undervoltage high off");
    chk_bit(uvo, 1'b1, "undervoltage flag");
    uv_trip = 0;
    cyc(3);
    chk_drv(lows(), "hysteresis holds off");
    uv_rel = 1; // Supply back above the release level.
    cyc(3);
    chk_drv(pair(hall, dir), "undervoltage released");
    $display("test undervoltage done");
  endtask : t_uv

  task automatic t_stop();
    stop = 1;
    cyc(3);
    chk_drv(6'h00, "stop drives");
    chk_bit(oe, 1'b0, "stop high impedance");
    chk_bit(psave, 1'b1, "power save");
    chk_bit(r5v, 1'b1, "regulator kept");
    stop = 0;
    cyc(4);
    chk_bit(psave, 1'b0, "power save off");
    uv_op = 1;
    cyc(3);
    chk_bit(oe, 1'b0, "low supply high impedance");
    uv_op = 0;
    cyc(4);
    chk_drv(pair(hall, dir), "run again");
    chk_bit(oe, 1'b1, "outputs driven again");
    $display("test stop done");
  endtask : t_stop

  task automatic t_lock();
    step();
    cyc(LOCK_N - 50);
    chk_bit(lck, 1'b0, "no early lock");
    cyc(100);
    chk_bit(lck, 1'b1, "lock");
    chk_drv(lows(), "lock high off");
    pmode = 1;
    poff = 1;
    cyc(60);
    pmode = 0;
    cyc(4);
    chk_bit(lck, 1'b0, "lock cleared by zero duty");
    $display("test lock done");
  endtask : t_lock

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // *****
  // Clock, sequence and watchdog
  // *****
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    cyc(20);
    chk_drv(6'h00, "reset drives");
    chk_bit(psave, 1'b1, "reset power save");
    chk_bit(uvo, 1'b1, "reset undervoltage");
    rst_n = 1;
    cyc(4);
    t_comm();
    t_chop();
    t_pulse();
    t_limit();
    t_uv();
    t_stop();
    t_lock();
    conclude();
  end
  // The run needs about 15100 cycles; this bound leaves wide margin.
  initial begin
    #(40000 * 25);
    err_total++;
    conclude();
  end
endmodule : tb

`default_nettype wire
